// ==== sim/next_stage.sv ====
// Far side of the counter: a cascaded upper stage and a count-of-nine decode.
// Assumes it shares aclk and aresetn with the counter it watches.
`timescale 1ns/1ns
`default_nettype none
module next_stage (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic carry_in,
  input wire logic decode_en,
  input wire logic [3:0] count_in,
  output logic zero_n_out,
  output logic [3:0] hi_count
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_count <= 4'h0;
    end else if (carry_in) begin
      hi_count <= hi_count + 4'h1;
    end
  end
  // decode nine, clear on next edge
  assign zero_n_out = !(decode_en && count_in == 4'h9);
endmodule : next_stage
`default_nettype wire

// ==== sim/tb.sv ====
// Bench for the counter: pin sequences plus AXI4-Lite register accesses.
// Assumes counter_regs.svh on the include path and next_stage as far side.
`include "counter_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] pdata = 4'h0;
  logic preset_n = 1'b1;
  logic pin_zero_n = 1'b1;
  logic ep = 1'b0;
  logic et = 1'b0;
  logic dec_en = 1'b0;
  logic [3:0] cnt, hi;
  logic carry, dec_zero_n, zero_n_mix;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0;
  int n_checks = 0;
  // Decode shares the clear line with the bench, wired-AND
  assign zero_n_mix = pin_zero_n & dec_zero_n;
  always #4 aclk = ~aclk;
  sync_counter dut (.aclk(aclk), .aresetn(aresetn), .preset_data(pdata),
    .preset_n(preset_n), .zero_n(zero_n_mix), .parallel_count_enable(ep),
    .trickle_count_enable(et), .count_value_out(cnt), .ripple_carry_out(carry),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  next_stage far (.aclk(aclk), .aresetn(aresetn), .carry_in(carry), .decode_en(dec_en),
    .count_in(cnt), .zero_n_out(dec_zero_n), .hi_count(hi));
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One edge: drive pins, check present count and carry mid-cycle
  task cyc(input logic zn, pn, p, t, input logic [3:0] d, input logic [3:0] now);
    pin_zero_n <= zn;
    preset_n <= pn;
    ep <= p;
    et <= t;
    pdata <= d;
    @(negedge aclk);
    chk({28'h0, cnt}, {28'h0, now});
    chk({31'h0, carry}, {31'h0, t && now == 4'hf});
    @(posedge aclk);
  endtask : cyc
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] r);
    int i;
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (!aw && !w && bvalid && bready) break;
      if (awready) aw = 1'b0;
      if (wready) w = 1'b0;
      awvalid <= aw;
      wvalid <= w;
      // Ready a cycle late, so the slave must hold its response meanwhile
      bready <= !aw && !w && bvalid;
    end
    bready <= 1'b0;
    if (i == 40) begin
      error_cnt++;
      report_and_stop();
    end
    chk({30'h0, bresp}, {30'h0, r});
    @(posedge aclk);
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    logic ar;
    ar = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (!ar && rvalid && rready) break;
      if (arready) ar = 1'b0;
      arvalid <= ar;
      // Ready a cycle late, so the slave must hold its read data meanwhile
      rready <= !ar && rvalid;
    end
    rready <= 1'b0;
    if (i == 40) begin
      error_cnt++;
      report_and_stop();
    end
    chk(rdata, d);
    chk({30'h0, rresp}, {30'h0, r});
    @(posedge aclk);
  endtask : axi_rd
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(1, 1, 1, 1, 4'h0, 4'h0);
    cyc(0, 1, 1, 1, 4'h0, 4'h1);
    cyc(1, 0, 0, 0, 4'hc, 4'h0);
    cyc(1, 1, 1, 1, 4'h0, 4'hc);
    cyc(1, 1, 1, 1, 4'h0, 4'hd);
    cyc(1, 1, 1, 1, 4'h0, 4'he);
    cyc(1, 1, 1, 1, 4'h0, 4'hf);
    cyc(1, 1, 0, 1, 4'h0, 4'h0);
    cyc(1, 1, 1, 0, 4'h0, 4'h0);
    cyc(1, 0, 1, 0, 4'hf, 4'h0);
    cyc(1, 1, 0, 0, 4'h0, 4'hf);
    cyc(1, 1, 0, 1, 4'h0, 4'hf);
    cyc(0, 0, 1, 1, 4'h5, 4'hf);
    cyc(1, 1, 0, 0, 4'h0, 4'h0);
    chk({28'h0, hi}, 32'h3);
    $display("test pins done");
    dec_en <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      cyc(1, 1, 1, 1, 4'h0, 4'(i % 10));
    end
    dec_en <= 1'b0;
    cyc(1, 0, 0, 0, 4'h3, 4'h2);
    cyc(1, 1, 0, 0, 4'h0, 4'h3);
    $display("test decode done");
    axi_rd(`REG_STATUS, 32'h3, `RESP_OKAY);
    axi_wr(`REG_CMD, 32'ha2, 4'hf, `RESP_OKAY);
    axi_rd(`REG_STATUS, 32'ha, `RESP_OKAY);
    axi_rd(`REG_CMD, 32'ha0, `RESP_OKAY);
    axi_wr(`REG_CMD, 32'h1, 4'hf, `RESP_OKAY);
    axi_rd(`REG_STATUS, 32'h0, `RESP_OKAY);
    axi_wr(`REG_CMD, 32'hf2, 4'he, `RESP_OKAY);
    axi_rd(`REG_STATUS, 32'h0, `RESP_OKAY);
    axi_rd(`REG_CMD, 32'h0, `RESP_OKAY);
    axi_wr(8'h08, 32'h0, 4'hf, `RESP_SLVERR);
    axi_rd(8'h08, 32'h0, `RESP_SLVERR);
    axi_wr(`REG_STATUS, 32'h3, 4'hf, `RESP_OKAY);
    axi_rd(`REG_STATUS, 32'h0, `RESP_OKAY);
    $display("test registers done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire

// ==== verilog/counter_pkg.sv ====
// Types shared by the counter: bus channel states and the state record.
// Assumes counter_regs.svh is on the include path.
`include "counter_regs.svh"

package counter_pkg;

  typedef enum logic [0:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_e;

  typedef enum logic [0:0] {
    RD_IDLE,
    RD_DATA
  } rd_state_e;

  typedef struct packed {
    logic [`CNT_W-1:0] cnt;
    wr_state_e wst;
    logic aw_got;
    logic w_got;
    logic [`ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    rd_state_e rst;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic cmd_zero;
    logic cmd_preset;
    logic [`CNT_W-1:0] cmd_data;
  } state_s;

endpackage : counter_pkg

// ==== verilog/counter_regs.svh ====
// Constants for the 4-bit presettable counter and its register window.
// Assumes inclusion by bare name from the package and the counter file.
`ifndef COUNTER_REGS_SVH
`define COUNTER_REGS_SVH

`define CNT_W 4
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define CNT_MAX 4'hf

`define ADDR_W 8
`define REG_STATUS 8'h00
`define REG_CMD 8'h04

`define CMD_ZERO_BIT 0
`define CMD_PRESET_BIT 1
`define CMD_DATA_LSB 4
`define CMD_DATA_MSB 7
`define STAT_CARRY_BIT 4

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== verilog/sync_counter.sv ====
// 4-bit synchronous presettable binary counter with cascade carry,
// plus an AXI4-Lite window for status and one-shot software commands.
// Assumes all pins are synchronous to aclk; neighbour stages share aclk.
//
// How it works
// - Four flip-flops hold the count, shown on four parallel outputs.
// - All count bits load together on the rising clock edge.
// - Low preset input loads the preset data, ignoring both enables.
// - Low zero input clears the count to 0000, ignoring both enables.
// - Count up only with both enables high; otherwise hold.
// - Plain binary count wraps from fifteen to zero.
// - Carry high exactly when trickle enable high and count is 1111.
// - Control changes affect the count only at the next rising edge.
// - Only levels sampled at the edge choose hold, preset or count.
`include "counter_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module sync_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CNT_W-1:0] preset_data,
  input wire logic preset_n,
  input wire logic zero_n,
  input wire logic parallel_count_enable,
  input wire logic trickle_count_enable,
  output logic [`CNT_W-1:0] count_value_out,
  output logic ripple_carry_out,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  counter_pkg::state_s st_r;
  counter_pkg::state_s st_nxt;

  logic zero_now;
  logic preset_now;
  logic count_now;
  logic [`CNT_W-1:0] load_val;
  logic aw_take;
  logic w_take;
  logic ar_take;

  function automatic logic at_full(input logic [`CNT_W-1:0] v);
    at_full = (v == `CNT_MAX);
  endfunction : at_full

  function automatic logic mapped(input logic [`ADDR_W-1:0] a);
    mapped = (a == `REG_STATUS) || (a == `REG_CMD);
  endfunction : mapped

  assign zero_now = !zero_n || st_r.cmd_zero;
  assign preset_now = !preset_n || st_r.cmd_preset;
  assign count_now = parallel_count_enable && trickle_count_enable;
  // Pin preset wins over a software preset landing on the same edge
  assign load_val = !preset_n ? preset_data : st_r.cmd_data;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  assign s_axi_awready = (st_r.wst == counter_pkg::WR_IDLE) && !st_r.aw_got;
  assign s_axi_wready = (st_r.wst == counter_pkg::WR_IDLE) && !st_r.w_got;
  assign s_axi_bvalid = (st_r.wst == counter_pkg::WR_RESP);
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = (st_r.rst == counter_pkg::RD_IDLE);
  assign s_axi_rvalid = (st_r.rst == counter_pkg::RD_DATA);
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  assign count_value_out = st_r.cnt;
  assign ripple_carry_out = trickle_count_enable && at_full(st_r.cnt);

  always_comb begin
    st_nxt = st_r;

    if (zero_now) begin
      st_nxt.cnt = `CNT_ZERO;
    end else if (preset_now) begin
      st_nxt.cnt = load_val;
    end else if (count_now) begin
      st_nxt.cnt = st_r.cnt + `CNT_ONE;
    end

    // Software commands are one-shot: used on one edge, then dropped
    st_nxt.cmd_zero = 1'b0;
    st_nxt.cmd_preset = 1'b0;

    case (st_r.wst)
      counter_pkg::WR_IDLE: begin
        if (aw_take) begin
          st_nxt.aw_got = 1'b1;
          st_nxt.waddr = s_axi_awaddr;
        end
        if (w_take) begin
          st_nxt.w_got = 1'b1;
          st_nxt.wdata = s_axi_wdata;
          st_nxt.wstrb = s_axi_wstrb;
        end
        // Address and data come in either order; answer once both are in
        if (st_nxt.aw_got && st_nxt.w_got) begin
          st_nxt.wst = counter_pkg::WR_RESP;
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got = 1'b0;
          st_nxt.bresp = mapped(st_nxt.waddr) ? `RESP_OKAY : `RESP_SLVERR;
          // Only byte lane 0 holds command bits
          if (st_nxt.waddr == `REG_CMD && st_nxt.wstrb[0]) begin
            st_nxt.cmd_zero = st_nxt.wdata[`CMD_ZERO_BIT];
            st_nxt.cmd_preset = st_nxt.wdata[`CMD_PRESET_BIT];
            st_nxt.cmd_data = st_nxt.wdata[`CMD_DATA_MSB:`CMD_DATA_LSB];
          end
        end
      end
      counter_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          st_nxt.wst = counter_pkg::WR_IDLE;
        end
      end
      default: begin
        st_nxt.wst = counter_pkg::WR_IDLE;
      end
    endcase

    case (st_r.rst)
      counter_pkg::RD_IDLE: begin
        if (ar_take) begin
          st_nxt.rst = counter_pkg::RD_DATA;
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = `RESP_OKAY;
          if (s_axi_araddr == `REG_STATUS) begin
            st_nxt.rdata[`CNT_W-1:0] = st_r.cnt;
            st_nxt.rdata[`STAT_CARRY_BIT] = ripple_carry_out;
          end else if (s_axi_araddr == `REG_CMD) begin
            st_nxt.rdata[`CMD_DATA_MSB:`CMD_DATA_LSB] = st_r.cmd_data;
          end else begin
            st_nxt.rresp = `RESP_SLVERR;
          end
        end
      end
      counter_pkg::RD_DATA: begin
        if (s_axi_rready) begin
          st_nxt.rst = counter_pkg::RD_IDLE;
        end
      end
      default: begin
        st_nxt.rst = counter_pkg::RD_IDLE;
      end
    endcase
  end

  // Reset is added for the bus side; a bare counter core would power up unknown
  // one edge for all bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Checks on the counter core

  property p_zero;
    @(posedge aclk) disable iff (!aresetn)
    !zero_n |=> (count_value_out == `CNT_ZERO);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero input did not clear the count");

  property p_zero_first;
    @(posedge aclk) disable iff (!aresetn)
    (!zero_n && !preset_n) |=> (count_value_out == `CNT_ZERO);
  endproperty
  a_zero_first: assert property (p_zero_first)
    else $error("preset overrode the zero input");

  property p_preset;
    @(posedge aclk) disable iff (!aresetn)
    (zero_n && !st_r.cmd_zero && !preset_n)
      |=> (count_value_out == $past(preset_data));
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset data not loaded");

  property p_count;
    @(posedge aclk) disable iff (!aresetn)
    (!zero_now && !preset_now && count_now)
      |=> (count_value_out == $past(count_value_out) + `CNT_ONE);
  endproperty
  a_count: assert property (p_count)
    else $error("enabled count did not advance by one");

  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
    (!zero_now && !preset_now && !count_now) |=> $stable(count_value_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count moved with no mode selected");

  property p_wrap;
    @(posedge aclk) disable iff (!aresetn)
    (!zero_now && !preset_now && count_now && count_value_out == `CNT_MAX)
      |=> (count_value_out == `CNT_ZERO) ##1 ($past(count_now) ||
      $past(zero_now) || $past(preset_now) || count_value_out == `CNT_ZERO);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("count did not wrap from fifteen to zero");

  property p_carry;
    @(posedge aclk) disable iff (!aresetn)
    ripple_carry_out == (trickle_count_enable && count_value_out == `CNT_MAX);
  endproperty
  a_carry: assert property (p_carry)
    else $error("ripple carry does not match terminal count");

  property p_no_early;
    @(posedge aclk) disable iff (!aresetn)
    ##1 (count_value_out != $past(count_value_out))
      |-> ($past(zero_now) || $past(preset_now) || $past(count_now));
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("count changed without a qualifying edge");

  property p_sw_zero;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && $rose(s_axi_bvalid) && st_r.cmd_zero)
      |=> (count_value_out == `CNT_ZERO);
  endproperty
  a_sw_zero: assert property (p_sw_zero)
    else $error("software zero command not applied");

  // Checks on the bus slave, plus carry low after a clear

  property p_bhold;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp));
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped before taken");

  property p_rhold;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata));
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped before taken");

  property p_rd_status;
    @(posedge aclk) disable iff (!aresetn)
    (ar_take && s_axi_araddr == `REG_STATUS)
      |=> (s_axi_rvalid && s_axi_rdata[`CNT_W-1:0] == $past(count_value_out));
  endproperty
  a_rd_status: assert property (p_rd_status)
    else $error("status read does not show the count");

  property p_rd_carry;
    @(posedge aclk) disable iff (!aresetn)
    (ar_take && s_axi_araddr == `REG_STATUS)
      |=> (s_axi_rdata[`STAT_CARRY_BIT] == $past(ripple_carry_out));
  endproperty
  a_rd_carry: assert property (p_rd_carry)
    else $error("status read does not show the carry");

  property p_sw_preset;
    @(posedge aclk) disable iff (!aresetn)
    ($rose(s_axi_bvalid) && st_r.cmd_preset && !st_r.cmd_zero && zero_n && preset_n)
      |=> (count_value_out == $past(st_r.cmd_data));
  endproperty
  a_sw_preset: assert property (p_sw_preset)
    else $error("software preset not applied");

  property p_zero_carry;
    @(posedge aclk) disable iff (!aresetn)
    !zero_n |=> !ripple_carry_out;
  endproperty
  a_zero_carry: assert property (p_zero_carry)
    else $error("carry high right after a clear");

endmodule : sync_counter

`default_nettype wire
